// ---- fpio_board.sv ----
// fpio_board: board side model that drives, pulls and senses the port pins
`timescale 1ns/10ps
module fpio_board
(
  input  wire logic       i_ref_clk,
  input  wire logic [3:0] i_pin_oe,
  input  wire logic [3:0] i_pin_out,
  input  wire logic [3:0] i_pin_pullup,
  input  wire logic [3:0] i_drv_en,
  input  wire logic [3:0] i_drv_val,
  output logic      [3:0] o_pin_lvl
);
  logic      [3:0] float_q = 4'h5;
  wire logic [3:0] board_drv;
  // lines nobody drives wander every cycle
  always @(posedge i_ref_clk)
    float_q <= ~float_q;
  // board lets go of any pin that the port drives
  assign board_drv = i_drv_en & ~i_pin_oe;
  // wire level: port driver, board, pull-up, else wandering
  assign o_pin_lvl = (i_pin_oe & i_pin_out) | (board_drv & i_drv_val)
                   | (~i_pin_oe & ~board_drv & (i_pin_pullup | float_q));
endmodule : fpio_board

// ---- fpio_pin_mux.sv ----
// fpio_pin_mux: per pin function precedence, drivers, pull-ups
`timescale 1ns/10ps
module fpio_pin_mux
  import fpio_pkg::*;
#(
  parameter int N = FPIO_PIN_COUNT
)
(
  input  wire logic [N-1:0] i_dir,
  input  wire logic [N-1:0] i_latch,
  input  wire logic         i_wake_on_change_disable,
  input  wire logic         i_pullup_disable,
  input  wire logic         i_tmr_ext_clk,
  input  wire logic         i_master_clear_input_en,
  input  wire logic         i_comparator_input_en,
  input  wire logic         i_comparator_output_en,
  input  wire logic         i_comparator_output,
  input  wire logic         i_osc_quarter_output_en,
  input  wire logic         i_osc_quarter_output,
  output logic      [N-1:0] o_oe,
  output logic      [N-1:0] o_out,
  output logic      [N-1:0] o_pullup,
  output logic      [N-1:0] o_wake_en
);

  // ********************************************************
  // one slice per pin
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_pin
      wire is_wake_pin = FPIO_WAKE_PINS[g];
      wire is_cmp_pin  = FPIO_CMP_PINS[g];
      wire is_master_clear_input     = (g == FPIO_PIN_INONLY) && i_master_clear_input_en;
      // input by direction, weak functions only on input pins
      wire as_input    = i_dir[g];
      wire pu_on       = is_wake_pin && as_input && !i_pullup_disable;
      wire wk_on       = is_wake_pin && as_input && !i_wake_on_change_disable;
      if (g == FPIO_PIN_INONLY)
      begin : g_inonly
        // never driven, master clear keeps pull-up, drops wake
        assign o_oe[g]      = 1'b0;
        assign o_out[g]     = 1'b0;
        assign o_pullup[g]  = is_master_clear_input | pu_on;
        assign o_wake_en[g] = wk_on & ~is_master_clear_input;
      end
      else if (g == FPIO_PIN_OSC)
      begin : g_osc
        // clock out, comparator out, timer clock in, direction
        assign o_oe[g]  = i_osc_quarter_output_en | i_comparator_output_en |
                          (~i_tmr_ext_clk & ~i_dir[g]);
        assign o_out[g] = i_osc_quarter_output_en ? i_osc_quarter_output :
                          i_comparator_output_en  ? i_comparator_output  :
                          i_latch[g];
        assign o_pullup[g]  = 1'b0;
        assign o_wake_en[g] = 1'b0;
      end
      else
      begin : g_gen
        // comparator input outranks the direction bit
        wire cmp_in = is_cmp_pin && i_comparator_input_en;
        assign o_oe[g]      = ~cmp_in & ~i_dir[g];
        assign o_out[g]     = i_latch[g];
        assign o_pullup[g]  = pu_on & ~cmp_in;
        assign o_wake_en[g] = wk_on & ~cmp_in;
      end
    end
  endgenerate

endmodule : fpio_pin_mux

// ---- fpio_pkg.sv ----
// fpio_pkg: constants and types shared by the four pin port block
package fpio_pkg;

  // ********************************************************
  // register addresses (data memory file addresses)
  // ********************************************************
  localparam logic [4:0] FPIO_ADDR_FLAGS = 5'h03;
  localparam logic [4:0] FPIO_ADDR_PINS  = 5'h06;

  // ********************************************************
  // widths and pin positions
  // ********************************************************
  localparam int         FPIO_PIN_COUNT  = 4;
  localparam int         FPIO_PIN_INONLY = 3;
  localparam int         FPIO_PIN_OSC    = 2;
  localparam logic [3:0] FPIO_WAKE_PINS  = 4'hB;  // pins 0, 1 and 3
  localparam logic [3:0] FPIO_CMP_PINS   = 4'h3;  // comparator inputs
  localparam logic [3:0] FPIO_ZERO4      = 4'h0;
  localparam logic [5:0] FPIO_ZERO6      = 6'h00;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [3:0] FPIO_DIR_RESET   = 4'hF;
  localparam logic [7:0] FPIO_OPT_RESET   = 8'hFF;
  localparam logic [3:0] FPIO_LATCH_RESET = 4'h0;
  localparam logic [7:0] FPIO_RDATA_RESET = 8'h00;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int FPIO_OPT_WAKE_DIS   = 7;
  localparam int FPIO_OPT_PULLUP_DIS = 6;
  localparam int FPIO_OPT_TMR_EXT    = 5;
  localparam int FPIO_FLAG_PIN_WAKE  = 7;
  localparam int FPIO_FLAG_CMP_WAKE  = 6;

  // ********************************************************
  // reset causes reported by the core
  // ********************************************************
  typedef enum logic [1:0] {
    FPIO_CAUSE_OTHER    = 2'b00,
    FPIO_CAUSE_PIN_WAKE = 2'b01,
    FPIO_CAUSE_CMP_WAKE = 2'b10
  } fpio_cause_t;

  // ********************************************************
  // sleep and wake states
  // ********************************************************
  typedef enum logic [1:0] {
    FPIO_ST_RUN   = 2'b00,
    FPIO_ST_SLEEP = 2'b01,
    FPIO_ST_WAKE  = 2'b10
  } fpio_state_t;

endpackage : fpio_pkg

// ---- fpio_port.sv ----
// fpio_port: four pin general purpose port with direction and wake logic
//
// Operation
// - port reads return pin levels, not latches
// - any reset sets all direction bits
// - upper four port bits read zero
// - pin three never gets an output driver
// - pull-up and wake each have their own global disable bit
// - master clear: pull-up on, no wake
// - direction loaded by instruction, never readable
// - direction one floats, zero drives latch
// - comparator input outranks direction on pins 0,1
// - pin two: clock out, comparator, timer, direction
// - inputs sampled only when the port is read
// - latches hold until the port is rewritten
// - bit set/clear rewrites all latches from pins
// - writes and pin reads both land on the edge that ends the cycle
// - flag seven marks a pin change wake reset
// - flag six marks a comparator wake reset
// - option bit seven disables change wake
// - option bit six disables weak pull-ups
// - output direction drops pull-up and wake
`timescale 1ns/10ps
module fpio_port
  import fpio_pkg::*;
#(
  parameter int N = FPIO_PIN_COUNT
)
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_nrst,
  // core reset other than power-on, with its cause
  input  wire logic         i_core_reset,
  input  wire logic [1:0]   i_reset_cause,
  // file register access from the datapath
  input  wire logic         i_rd_en,
  input  wire logic         i_wr_en,
  input  wire logic [4:0]   i_addr,
  input  wire logic [7:0]   i_wdata,
  output logic      [7:0]   o_rdata,
  output logic              o_rd_hit,
  // bit set and bit clear instructions
  input  wire logic         i_bit_op,
  input  wire logic [2:0]   i_bit_sel,
  input  wire logic         i_bit_set,
  // direction_load and option load instructions
  input  wire logic         i_direction_load,
  input  wire logic         i_option_load,
  // other functions sharing the pins
  input  wire logic         i_master_clear_input_en,
  input  wire logic         i_comparator_input_en,
  input  wire logic         i_comparator_output_en,
  input  wire logic         i_comparator_output,
  input  wire logic         i_osc_quarter_output_en,
  input  wire logic         i_osc_quarter_output,
  // sleep handshake with the core
  input  wire logic         i_sleep,
  output logic              o_wake_req,
  // pins
  input  wire logic [N-1:0] i_pin_in,
  output logic      [N-1:0] o_pin_out,
  output logic      [N-1:0] o_pin_oe,
  output logic      [N-1:0] o_pin_pullup,
  output logic      [N-1:0] o_timer_ext_clock_input,
  output logic      [7:0]   o_timer_pin_options,
  output logic      [1:0]   o_wake_flags
);

  // ********************************************************
  // storage
  // ********************************************************
  logic        [N-1:0] port_direction;     // write only
  logic        [7:0]   timer_pin_options;  // write only
  logic        [N-1:0] out_latch;
  logic        [N-1:0] last_read;          // reference for change wake
  logic                pin_wake_flag;
  logic                comparator_wake_flag;
  logic        [7:0]   rdata;
  logic                rd_hit;
  fpio_state_t         state;

  logic        [N-1:0] next_port_direction;
  logic        [7:0]   next_timer_pin_options;
  logic        [N-1:0] next_out_latch;
  logic        [N-1:0] next_last_read;
  logic                next_pin_wake_flag;
  logic                next_comparator_wake_flag;
  logic        [7:0]   next_rdata;
  logic                next_rd_hit;
  fpio_state_t         next_state;

  // ********************************************************
  // address decode
  // ********************************************************
  wire sel_pins  = (i_addr == FPIO_ADDR_PINS);
  wire sel_flags = (i_addr == FPIO_ADDR_FLAGS);
  wire wr_pins   = i_wr_en && sel_pins && !i_bit_op;
  wire wr_flags  = i_wr_en && sel_flags && !i_bit_op;
  wire rd_pins   = i_rd_en && sel_pins;
  wire rd_flags  = i_rd_en && sel_flags;
  wire rmw_pins  = i_bit_op && sel_pins;

  // ********************************************************
  // option fields
  // ********************************************************
  wire wake_on_change_disable = timer_pin_options[FPIO_OPT_WAKE_DIS];
  wire pullup_disable         = timer_pin_options[FPIO_OPT_PULLUP_DIS];
  wire tmr_ext_clk            = timer_pin_options[FPIO_OPT_TMR_EXT];

  // ********************************************************
  // read data views
  // ********************************************************
  // port view is the live pins, top nibble zero
  wire [7:0] pins_view  = {FPIO_ZERO4, i_pin_in};
  wire [7:0] flags_view = {pin_wake_flag, comparator_wake_flag, FPIO_ZERO6};

  // ********************************************************
  // read-modify-write on the port
  // ********************************************************
  // pins are read, one bit replaced, whole nibble written back
  wire [N-1:0] bit_mask  = N'(1) << i_bit_sel[1:0];
  wire         bit_in_rng = (i_bit_sel < 3'(N));
  // bit numbers four to seven touch no pin, latches still reload
  wire [N-1:0] rmw_mask  = bit_in_rng ? bit_mask : FPIO_ZERO4;
  wire [N-1:0] rmw_value = i_bit_set ? (i_pin_in | rmw_mask) :
                                       (i_pin_in & ~rmw_mask);

  // ********************************************************
  // pin function precedence
  // ********************************************************
  logic [N-1:0] wake_en;

  fpio_pin_mux #(
    .N (N)
  ) u_mux (
    .i_dir                    (port_direction),
    .i_latch                  (out_latch),
    .i_wake_on_change_disable (wake_on_change_disable),
    .i_pullup_disable         (pullup_disable),
    .i_tmr_ext_clk            (tmr_ext_clk),
    .i_master_clear_input_en  (i_master_clear_input_en),
    .i_comparator_input_en    (i_comparator_input_en),
    .i_comparator_output_en   (i_comparator_output_en),
    .i_comparator_output      (i_comparator_output),
    .i_osc_quarter_output_en  (i_osc_quarter_output_en),
    .i_osc_quarter_output     (i_osc_quarter_output),
    .o_oe                     (o_pin_oe),
    .o_out                    (o_pin_out),
    .o_pullup                 (o_pin_pullup),
    .o_wake_en                (wake_en)
  );

  // ********************************************************
  // change detection during sleep
  // ********************************************************
  // compare enabled pins against the last port read
  wire pin_changed = |((i_pin_in ^ last_read) & wake_en);

  // ********************************************************
  // direction and option registers
  // ********************************************************
  // loaded only by their own instructions, reset to all ones
  always_comb
  begin
    next_port_direction    = port_direction;
    next_timer_pin_options = timer_pin_options;
    // loads in a core reset cycle are dropped
    if (i_core_reset)
    begin
      next_port_direction    = FPIO_DIR_RESET;
      next_timer_pin_options = FPIO_OPT_RESET;
    end
    else
    begin
      if (i_direction_load)
        next_port_direction = i_wdata[N-1:0];
      if (i_option_load)
        next_timer_pin_options = i_wdata;
    end
  end

  // ********************************************************
  // output latches
  // ********************************************************
  // direction changes never touch the latches
  always_comb
  begin
    next_out_latch = out_latch;
    if (rmw_pins)
      next_out_latch = rmw_value;
    else if (wr_pins)
      next_out_latch = i_wdata[N-1:0];
  end

  // ********************************************************
  // read path
  // ********************************************************
  // pins caught on the edge that closes the reading cycle
  always_comb
  begin
    next_rdata     = FPIO_RDATA_RESET;
    next_rd_hit    = 1'b0;
    next_last_read = last_read;
    if (rd_pins)
    begin
      next_rdata     = pins_view;
      next_rd_hit    = 1'b1;
      next_last_read = i_pin_in;
    end
    else if (rd_flags)
    begin
      next_rdata  = flags_view;
      next_rd_hit = 1'b1;
    end
    // a bit op reads the pins too, so it moves the reference
    if (rmw_pins)
      next_last_read = i_pin_in;
  end

  // ********************************************************
  // wake cause flags
  // ********************************************************
  // set by the matching reset cause or a flags write, cleared by other causes
  always_comb
  begin
    next_pin_wake_flag        = pin_wake_flag;
    next_comparator_wake_flag = comparator_wake_flag;
    // a core reset outranks a software write in the same cycle
    if (i_core_reset)
    begin
      next_pin_wake_flag        = (i_reset_cause == FPIO_CAUSE_PIN_WAKE);
      next_comparator_wake_flag = (i_reset_cause == FPIO_CAUSE_CMP_WAKE);
    end
    else if (wr_flags)
    begin
      next_pin_wake_flag        = i_wdata[FPIO_FLAG_PIN_WAKE];
      next_comparator_wake_flag = i_wdata[FPIO_FLAG_CMP_WAKE];
    end
  end

  // ********************************************************
  // sleep state machine
  // ********************************************************
  // run, sleep on request, wake held until a core reset
  always_comb
  begin
    next_state = state;
    case (state)
      FPIO_ST_RUN:
      begin
        if (i_sleep && !i_core_reset)
          next_state = FPIO_ST_SLEEP;
      end
      FPIO_ST_SLEEP:
      begin
        if (i_core_reset)
          next_state = FPIO_ST_RUN;
        else if (pin_changed)
          next_state = FPIO_ST_WAKE;
      end
      FPIO_ST_WAKE:
      begin
        // request stands until the core resets
        if (i_core_reset)
          next_state = FPIO_ST_RUN;
      end
      default:
      begin
        next_state = FPIO_ST_RUN;
      end
    endcase
  end

  // ********************************************************
  // flip-flops
  // ********************************************************
  // configuration and latches
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      port_direction    <= FPIO_DIR_RESET;
      timer_pin_options <= FPIO_OPT_RESET;
      out_latch         <= FPIO_LATCH_RESET;
    end
    else
    begin
      port_direction    <= next_port_direction;
      timer_pin_options <= next_timer_pin_options;
      out_latch         <= next_out_latch;
    end
  end

  // read path and wake reference
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata     <= FPIO_RDATA_RESET;
      rd_hit    <= 1'b0;
      last_read <= FPIO_LATCH_RESET;
    end
    else
    begin
      rdata     <= next_rdata;
      rd_hit    <= next_rd_hit;
      last_read <= next_last_read;
    end
  end

  // flags and state, power-on clears both flags
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_wake_flag        <= 1'b0;
      comparator_wake_flag <= 1'b0;
      state                <= FPIO_ST_RUN;
    end
    else
    begin
      pin_wake_flag        <= next_pin_wake_flag;
      comparator_wake_flag <= next_comparator_wake_flag;
      state                <= next_state;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  // direction and option never appear on the read path
  assign o_rdata                 = rdata;
  assign o_rd_hit                = rd_hit;
  // wake request is a level that only a reset takes down
  assign o_wake_req              = (state == FPIO_ST_WAKE);
  assign o_wake_flags            = {pin_wake_flag, comparator_wake_flag};
  assign o_timer_pin_options     = timer_pin_options;
  // timer clock input is the raw pin level, not a latch
  assign o_timer_ext_clock_input = i_pin_in;

endmodule : fpio_port

// ---- fpio_port_props.sv ----
// fpio_port_props: concurrent checks on the port block pins
`timescale 1ns/10ps
module fpio_port_props
  import fpio_pkg::*;
#(
  parameter int N = FPIO_PIN_COUNT
)
(
  input  wire logic         i_ref_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_core_reset,
  input  wire logic [1:0]   i_reset_cause,
  input  wire logic         i_rd_en,
  input  wire logic [4:0]   i_addr,
  input  wire logic         i_master_clear_input_en,
  input  wire logic         i_comparator_input_en,
  input  wire logic         i_comparator_output_en,
  input  wire logic         i_comparator_output,
  input  wire logic         i_osc_quarter_output_en,
  input  wire logic         i_osc_quarter_output,
  input  wire logic [N-1:0] i_pin_in,
  input  wire logic [N-1:0] o_pin_out,
  input  wire logic [N-1:0] o_pin_oe,
  input  wire logic [N-1:0] o_pin_pullup,
  input  wire logic [7:0]   o_rdata,
  input  wire logic [7:0]   o_timer_pin_options,
  input  wire logic [1:0]   o_wake_flags,
  input  wire logic         o_wake_req
);
  // ********************************************************
  // pin and register checks
  // ********************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_rd_pin_level: assert property (i_rd_en && i_addr == FPIO_ADDR_PINS |=>
    o_rdata == {FPIO_ZERO4, $past(i_pin_in)}) else $error("port read not pin level");
  a_pin3_input: assert property (o_pin_oe[3] == 1'b0) else $error("pin three driven");
  a_reset_floats: assert property (i_core_reset |=>
    o_pin_oe[1:0] == 2'h0 && o_timer_pin_options == FPIO_OPT_RESET) else $error("reset left drivers");
  a_master_clear_input_pullup: assert property (i_master_clear_input_en |-> o_pin_pullup[3]) else $error("clear pull-up off");
  a_pullup_off: assert property (o_timer_pin_options[6] && !i_master_clear_input_en |->
    o_pin_pullup == FPIO_ZERO4) else $error("pull-up while disabled");
  a_out_no_pullup: assert property ((o_pin_oe[1:0] & o_pin_pullup[1:0]) == 2'h0)
    else $error("pull-up on output");
  a_cmp_inputs: assert property (i_comparator_input_en |-> o_pin_oe[1:0] == 2'h0)
    else $error("comparator input driven");
  a_osc_first: assert property (i_osc_quarter_output_en |->
    o_pin_oe[2] && o_pin_out[2] == i_osc_quarter_output) else $error("quarter clock not on pin");
  a_cmp_second: assert property (!i_osc_quarter_output_en && i_comparator_output_en |->
    o_pin_oe[2] && o_pin_out[2] == i_comparator_output) else $error("comparator not on pin");
  a_wake_cause: assert property (i_core_reset |=> !o_wake_req &&
    o_wake_flags == {$past(i_reset_cause) == FPIO_CAUSE_PIN_WAKE, $past(i_reset_cause) == FPIO_CAUSE_CMP_WAKE})
    else $error("wake flags wrong");
  a_wake_holds: assert property (o_wake_req && !i_core_reset |=> o_wake_req) else $error("wake dropped");
endmodule : fpio_port_props

bind fpio_port fpio_port_props #(.N(N)) fpio_port_props_i (.i_ref_clk, .i_nrst, .i_core_reset,
  .i_reset_cause, .i_rd_en, .i_addr, .i_master_clear_input_en, .i_comparator_input_en,
  .i_comparator_output_en, .i_comparator_output, .i_osc_quarter_output_en, .i_osc_quarter_output,
  .i_pin_in, .o_pin_out, .o_pin_oe, .o_pin_pullup, .o_rdata, .o_timer_pin_options, .o_wake_flags, .o_wake_req);

// ---- fpio_port_tb.sv ----
// fpio_port_tb: self-checking bench for the four pin port
`timescale 1ns/10ps
module fpio_port_tb
  import fpio_pkg::*;
;
  localparam int K_RD = 0, K_WR = 1, K_BIT = 2, K_DIR = 3, K_OPT = 4, K_RST = 5;
  logic       i_ref_clk, i_nrst, i_core_reset, i_rd_en, i_wr_en, i_bit_op, i_bit_set, i_sleep;
  logic       i_direction_load, i_option_load, i_master_clear_input_en, i_comparator_input_en;
  logic       i_comparator_output_en, i_comparator_output, i_osc_quarter_output_en, i_osc_quarter_output;
  logic [1:0] i_reset_cause, o_wake_flags;
  logic [2:0] i_bit_sel;
  logic [4:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_timer_pin_options;
  logic [3:0] pin_lvl, drv_en, drv_val, o_pin_out, o_pin_oe, o_pin_pullup, o_timer_ext_clock_input;
  logic       o_rd_hit, o_wake_req;
  int         failures, n_compared, cycles;

  fpio_port fpio_port_i (.i_ref_clk, .i_nrst, .i_core_reset, .i_reset_cause, .i_rd_en, .i_wr_en,
    .i_addr, .i_wdata, .o_rdata, .o_rd_hit, .i_bit_op, .i_bit_sel, .i_bit_set, .i_direction_load,
    .i_option_load, .i_master_clear_input_en, .i_comparator_input_en, .i_comparator_output_en,
    .i_comparator_output, .i_osc_quarter_output_en, .i_osc_quarter_output, .i_sleep, .o_wake_req,
    .i_pin_in(pin_lvl), .o_pin_out, .o_pin_oe, .o_pin_pullup, .o_timer_ext_clock_input,
    .o_timer_pin_options, .o_wake_flags);
  fpio_board fpio_board_i (.i_ref_clk, .i_pin_oe(o_pin_oe), .i_pin_out(o_pin_out),
    .i_pin_pullup(o_pin_pullup), .i_drv_en(drv_en), .i_drv_val(drv_val), .o_pin_lvl(pin_lvl));

  // ********************************************************
  // clock, watchdog and helpers
  // ********************************************************
  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  // cut a hang short
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one instruction pulse, taken at the next edge
  task automatic op(input int kind, input logic [4:0] addr, input logic [7:0] data);
    @(posedge i_ref_clk);
    i_addr <= addr;
    i_wdata <= data;
    i_bit_sel <= data[2:0];
    i_bit_set <= data[3];
    i_reset_cause <= data[1:0];
    {i_rd_en, i_wr_en, i_bit_op} <= {kind == K_RD, kind == K_WR, kind == K_BIT};
    {i_direction_load, i_option_load, i_core_reset} <= {kind == K_DIR, kind == K_OPT, kind == K_RST};
    @(posedge i_ref_clk);
    {i_rd_en, i_wr_en, i_bit_op, i_direction_load, i_option_load, i_core_reset} <= 6'h00;
    #1;
  endtask : op
  task automatic rd(input logic [4:0] addr, input logic [7:0] exp);
    op(K_RD, addr, 8'h00);
    check(o_rdata, exp);
    check(8'(o_rd_hit), 8'((addr == FPIO_ADDR_PINS) || (addr == FPIO_ADDR_FLAGS)));
  endtask : rd

  // ********************************************************
  // test sequence
  // ********************************************************
  initial
  begin
    {i_core_reset, i_rd_en, i_wr_en, i_bit_op, i_bit_set, i_sleep, i_direction_load, i_option_load} = 8'h00;
    {i_master_clear_input_en, i_comparator_input_en, i_comparator_output_en, i_comparator_output} = 4'h0;
    {i_osc_quarter_output_en, i_osc_quarter_output, i_reset_cause, i_bit_sel, i_addr, i_wdata} = 20'h00000;
    {i_nrst, drv_en, drv_val} = 9'h0F5;
    repeat (3) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    #1;
    check(8'(o_pin_oe), 8'h00);
    check(o_timer_pin_options, FPIO_OPT_RESET);
    rd(FPIO_ADDR_PINS, 8'h05);
    check(8'(o_timer_ext_clock_input), 8'h05);
    rd(5'h07, 8'h00);
    $display("test reset done");
    drv_en <= 4'h8;
    drv_val <= 4'h8;
    op(K_WR, FPIO_ADDR_PINS, 8'hFA);
    op(K_OPT, 5'h00, 8'h00);
    op(K_DIR, 5'h00, 8'h08);
    check(8'(o_pin_oe), 8'h07);
    check(8'(o_pin_out[2:0]), 8'h02);
    check(8'(o_pin_pullup), 8'h08);
    rd(FPIO_ADDR_PINS, 8'h0A);
    op(K_DIR, 5'h00, 8'h0F);
    check(8'(o_pin_oe), 8'h00);
    rd(5'h00, 8'h00);
    op(K_DIR, 5'h00, 8'h08);
    check(8'(o_pin_out[2:0]), 8'h02);
    $display("test direction done");
    drv_en <= 4'hE;
    drv_val <= 4'h4;
    op(K_DIR, 5'h00, 8'h0E);
    op(K_BIT, FPIO_ADDR_PINS, 8'h02);
    check(8'(o_pin_out), 8'h00);
    op(K_BIT, FPIO_ADDR_PINS, 8'h08);
    op(K_DIR, 5'h00, 8'h08);
    check(8'(o_pin_out[2:0]), 8'h05);
    $display("test bit op done");
    for (int m = 0; m < 4; m++)
    begin
      op(K_OPT, 5'h00, (m == 2) ? 8'h20 : 8'h00);
      i_osc_quarter_output_en <= (m == 0);
      i_osc_quarter_output <= 1'b1;
      i_comparator_output_en <= (m < 2);
      i_comparator_input_en <= (m == 1);
      @(posedge i_ref_clk);
      #1;
      check(8'({o_pin_oe[2], o_pin_oe[2] & o_pin_out[2]}), (m == 1) ? 8'h02 : (m == 2) ? 8'h00 : 8'h03);
      check(8'(o_pin_oe[1:0]), (m == 1) ? 8'h00 : 8'h03);
    end
    {i_osc_quarter_output_en, i_comparator_output_en, i_comparator_input_en} <= 3'h0;
    op(K_WR, FPIO_ADDR_PINS, 8'h02);
    rd(FPIO_ADDR_PINS, 8'h02);
    $display("test precedence done");
    drv_en <= 4'hF;
    drv_val <= 4'h8;
    op(K_DIR, 5'h00, 8'h0F);
    rd(FPIO_ADDR_PINS, 8'h08);
    i_sleep <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    drv_val <= 4'h9;
    repeat (2) @(posedge i_ref_clk);
    #1;
    check(8'(o_wake_req), 8'h01);
    i_sleep <= 1'b0;
    for (int c = 0; c < 3; c++)
    begin
      op(K_RST, 5'h00, (c == 0) ? 8'h01 : (c == 1) ? 8'h02 : 8'h00);
      check({o_wake_req, o_pin_oe, 3'h0}, 8'h00);
      rd(FPIO_ADDR_FLAGS, (c == 0) ? 8'h80 : (c == 1) ? 8'h40 : 8'h00);
    end
    i_sleep <= 1'b1;
    i_master_clear_input_en <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    drv_val <= 4'h0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    check(8'(o_wake_req), 8'h00);
    check(8'(o_pin_pullup), 8'h08);
    op(K_OPT, 5'h00, 8'h00);
    @(posedge i_ref_clk);
    #1;
    check(8'(o_wake_req), 8'h00);
    check(8'(o_pin_pullup), 8'h0B);
    $display("test wake done");
    final_report();
  end
endmodule : fpio_port_tb
